// File: rtl/ssx_alu.sv
// Combinational subtract, swap and exclusive-OR unit with status outputs
`timescale 1ns/100ps
module ssx_alu
   import ssx_pkg::*;
#(
   parameter int DW = DATA_W
)
(
   // Operation and operands
   input wire logic [CMD_OP_W-1:0] op,
   input wire logic [DW-1:0] opnd,
   input wire logic [DW-1:0] work,
   // Result and flags
   output logic [DW-1:0] res,
   output logic zero,
   output logic half,
   output logic carry
);

   // ==========================================================
   // Subtraction as opnd + ~work + 1, so carry out means no borrow
   logic [DW:0] diff;
   logic [NIB_W:0] diff_lo;

   assign diff = {1'b0, opnd} + {1'b0, ~work} + {{DW{1'b0}}, 1'b1};
   assign diff_lo = {1'b0, opnd[NIB_W-1:0]} + {1'b0, ~work[NIB_W-1:0]}
                    + {{NIB_W{1'b0}}, 1'b1};

   // Result select; unknown codes pass the operand unchanged
   always_comb
   begin
      case (op)
         OP_SUB_REG, OP_SUB_IMM: res = diff[DW-1:0];
         OP_XOR_REG, OP_XOR_IMM: res = work ^ opnd;
         OP_SWAP: res = {opnd[NIB_W-1:0], opnd[DW-1:NIB_W]};
         default: res = opnd;
      endcase
   end

   // Flags; the caller decides which of them are kept
   assign zero = (res == {DW{1'b0}});
   assign half = diff_lo[NIB_W];
   assign carry = diff[DW];

endmodule

// File: rtl/ssx_exec_top.sv
// Execution datapath for subtract, swap, exclusive-OR, table and timer moves
//
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
module ssx_exec_top
   import ssx_pkg::*;
#(
   parameter int DW = DATA_W
)
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic [APB_AW-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [APB_DW-1:0] pwdata,
   output logic [APB_DW-1:0] prdata,
   output logic pready,
   output logic pslverr,
   // Program ROM
   output logic [ROM_AW-1:0] rom_addr,
   output logic rom_rd,
   input wire logic [ROM_DW-1:0] rom_data,
   // Timer mode towards the timer
   output logic [DW-1:0] timer0_mode
);

   // ==========================================================
   // Declarations
   ssx_state_t state_r;
   logic [APB_DW-1:0] prdata_r;
   logic pready_r, pslverr_r;
   logic [ROM_AW-1:0] rom_addr_r;
   logic rom_rd_r;
   logic [DW-1:0] work_r, tptr_r, tmode_r;
   logic [ROM_HI_W-1:0] tdata_r;
   logic [FILE_AW-1:0] faddr_r;
   logic zero_r, half_r, carry_r;
   logic [CMD_OP_W-1:0] cmd_op_r;
   logic cmd_tgt_r;
   logic [FILE_AW-1:0] cmd_reg_r;
   logic [DW-1:0] cmd_imm_r;
   logic [DW-1:0] rf_rdata, rf_apb_rdata, opnd, alu_res, exec_res;
   logic alu_zero, alu_half, alu_carry;
   logic setup_ok, access, wr_fire, exec_go, busy;
   logic wr_work, wr_file, upd_all, upd_zero;
   logic rf_we;
   logic [FILE_AW-1:0] rf_waddr;
   logic [DW-1:0] rf_wdata;
   logic [APB_DW-1:0] rd_val;
   logic rd_hit;

   // Operations whose operand comes from the register file
   function automatic logic is_reg_op(input logic [CMD_OP_W-1:0] op);
      is_reg_op = (op == OP_SUB_REG) || (op == OP_SWAP) ||
                  (op == OP_XOR_REG);
   endfunction

   // Operations that write the working register whatever the target
   function automatic logic is_work_op(input logic [CMD_OP_W-1:0] op);
      is_work_op = (op == OP_SUB_IMM) || (op == OP_XOR_IMM) ||
                   (op == OP_T0_READ);
   endfunction

   // ==========================================================
   // APB handshake: one wait state, writes land on the pready edge
   assign setup_ok = psel & penable & ~pready_r;
   assign access = psel & penable & pready_r;
   assign wr_fire = access & pwrite;
   assign busy = (state_r != ST_IDLE);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= '0;
      end
      else
      begin
         pready_r <= setup_ok;
         pslverr_r <= setup_ok & ~rd_hit;
         if (setup_ok && !pwrite)
            prdata_r <= rd_val;
      end
   end

   // Read decode; unmapped offsets read zero and flag an error
   always_comb
   begin
      rd_val = '0;
      rd_hit = 1'b1;
      case (paddr)
         OFF_CMD: rd_val = {8'h00, cmd_imm_r, 2'h0, cmd_reg_r, 3'h0,
                            cmd_tgt_r, cmd_op_r};
         OFF_STAT:
         begin
            rd_val[ST_BUSY_BIT] = busy;
            rd_val[ST_ZERO_BIT] = zero_r;
            rd_val[ST_HALF_BIT] = half_r;
            rd_val[ST_CARRY_BIT] = carry_r;
         end
         OFF_WORK: rd_val[DW-1:0] = work_r;
         OFF_TPTR: rd_val[DW-1:0] = tptr_r;
         OFF_TDATA: rd_val[ROM_HI_W-1:0] = tdata_r;
         OFF_T0MODE: rd_val[DW-1:0] = tmode_r;
         OFF_FADDR: rd_val[FILE_AW-1:0] = faddr_r;
         OFF_FDATA: rd_val[DW-1:0] = rf_apb_rdata;
         default: rd_hit = 1'b0;
      endcase
   end

   // ==========================================================
   // Command capture and sequencer; commands while busy are dropped
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cmd_op_r <= OP_NOP;
         cmd_tgt_r <= 1'b0;
         cmd_reg_r <= '0;
         cmd_imm_r <= RST_BYTE;
      end
      else if (wr_fire && paddr == OFF_CMD && !busy)
      begin
         cmd_op_r <= pwdata[CMD_OP_LSB +: CMD_OP_W];
         cmd_tgt_r <= pwdata[CMD_TGT_BIT];
         cmd_reg_r <= pwdata[CMD_REG_LSB +: FILE_AW];
         cmd_imm_r <= pwdata[CMD_IMM_LSB +: DW];
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         state_r <= ST_IDLE;
      else
      begin
         case (state_r)
            ST_IDLE:
               if (wr_fire && paddr == OFF_CMD)
                  state_r <= ST_EXEC;
            ST_EXEC:
               // The ROM needs a second cycle to answer
               if (cmd_op_r == OP_TABLE)
                  state_r <= ST_TABLE;
               else
                  state_r <= ST_IDLE;
            ST_TABLE: state_r <= ST_IDLE;
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // ==========================================================
   // Operand selection and arithmetic
   assign exec_go = (state_r == ST_EXEC);
   assign opnd = is_reg_op(cmd_op_r) ? rf_rdata : cmd_imm_r;
   assign exec_res = (cmd_op_r == OP_T0_READ) ? tmode_r : alu_res;
   assign wr_work = exec_go & (is_work_op(cmd_op_r) |
                    (is_reg_op(cmd_op_r) & ~cmd_tgt_r));
   assign wr_file = exec_go & is_reg_op(cmd_op_r) & cmd_tgt_r;
   assign upd_all = exec_go & ((cmd_op_r == OP_SUB_REG) |
                    (cmd_op_r == OP_SUB_IMM));
   assign upd_zero = exec_go & ((cmd_op_r == OP_XOR_REG) |
                     (cmd_op_r == OP_XOR_IMM));

   ssx_alu #(.DW(DW)) u_alu (
      .op(cmd_op_r),
      .opnd(opnd),
      .work(work_r),
      .res(alu_res),
      .zero(alu_zero),
      .half(alu_half),
      .carry(alu_carry)
   );

   // File write: execution beats a colliding software write
   assign rf_we = wr_file | (wr_fire & (paddr == OFF_FDATA));
   assign rf_waddr = wr_file ? cmd_reg_r : faddr_r;
   assign rf_wdata = wr_file ? exec_res : pwdata[DW-1:0];

   ssx_regfile #(.DW(DW), .AW(FILE_AW), .DEPTH(FILE_DEPTH)) u_file (
      .clk(pclk),
      .we(rf_we),
      .waddr(rf_waddr),
      .wdata(rf_wdata),
      .raddr_a(cmd_reg_r),
      .rdata_a(rf_rdata),
      .raddr_b(faddr_r),
      .rdata_b(rf_apb_rdata)
   );

   // ==========================================================
   // Working register: datapath has priority over software
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         work_r <= RST_BYTE;
      else if (wr_work)
         work_r <= exec_res;
      else if (state_r == ST_TABLE)
         work_r <= rom_data[DW-1:0];
      else if (wr_fire && paddr == OFF_WORK)
         work_r <= pwdata[DW-1:0];
   end

   // Flags: hardware update wins over a software restore
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         zero_r <= 1'b0;
         half_r <= 1'b0;
         carry_r <= 1'b0;
      end
      else if (upd_all)
      begin
         zero_r <= alu_zero;
         half_r <= alu_half;
         carry_r <= alu_carry;
      end
      else if (upd_zero)
         zero_r <= alu_zero;
      else if (wr_fire && paddr == OFF_STAT)
      begin
         zero_r <= pwdata[ST_ZERO_BIT];
         half_r <= pwdata[ST_HALF_BIT];
         carry_r <= pwdata[ST_CARRY_BIT];
      end
   end

   // Timer mode register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         tmode_r <= RST_BYTE;
      else if (exec_go && cmd_op_r == OP_T0_LOAD)
         tmode_r <= work_r;
      else if (wr_fire && paddr == OFF_T0MODE)
         tmode_r <= pwdata[DW-1:0];
   end

   // Table pointer and file address, software only
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tptr_r <= RST_BYTE;
         faddr_r <= '0;
      end
      else
      begin
         if (wr_fire && paddr == OFF_TPTR)
            tptr_r <= pwdata[DW-1:0];
         if (wr_fire && paddr == OFF_FADDR)
            faddr_r <= pwdata[FILE_AW-1:0];
      end
   end

   // Table high data catches the upper ROM bits
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         tdata_r <= '0;
      else if (state_r == ST_TABLE)
         tdata_r <= rom_data[ROM_HI_LSB +: ROM_HI_W];
      else if (wr_fire && paddr == OFF_TDATA)
         tdata_r <= pwdata[ROM_HI_W-1:0];
   end

   // ROM request: strobe stands during the table cycle only, address holds until the next table read
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rom_addr_r <= '0;
         rom_rd_r <= 1'b0;
      end
      else
      begin
         rom_rd_r <= exec_go & (cmd_op_r == OP_TABLE);
         if (exec_go && cmd_op_r == OP_TABLE)
            rom_addr_r <= {tptr_r[PTR_BITS-1:0], work_r};
      end
   end

   // Outputs straight from flip-flops
   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign rom_addr = rom_addr_r;
   assign rom_rd = rom_rd_r;
   assign timer0_mode = tmode_r;

   // ==========================================================
   // Assertions
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_sub_reg_result: assert property ((exec_go && cmd_op_r == OP_SUB_REG
      && !cmd_tgt_r) |=> work_r == DW'($past(rf_rdata) - $past(work_r)))
      else $error("register subtract result wrong");
   a_target_file: assert property ((exec_go && is_reg_op(cmd_op_r)
      && cmd_tgt_r) |-> rf_we && rf_waddr == cmd_reg_r ##1 $stable(work_r))
      else $error("write back to register file missing");
   a_borrow_flag: assert property (upd_all |=>
      carry_r == ($past(opnd) >= $past(work_r)))
      else $error("borrow-not flag wrong");
   a_imm_sub: assert property ((exec_go && cmd_op_r == OP_SUB_IMM) |=>
      work_r == DW'($past(cmd_imm_r) - $past(work_r))
      && zero_r == (work_r == RST_BYTE))
      else $error("immediate subtract wrong");
   a_swap_flags: assert property ((exec_go && cmd_op_r == OP_SWAP) |=>
      $stable(zero_r) && $stable(half_r) && $stable(carry_r))
      else $error("swap changed a flag");
   a_swap_value: assert property ((exec_go && cmd_op_r == OP_SWAP) |->
      exec_res == {opnd[NIB_W-1:0], opnd[DW-1:NIB_W]})
      else $error("swap value wrong");
   a_table_addr: assert property ((exec_go && cmd_op_r == OP_TABLE) |=>
      rom_rd_r && rom_addr_r == {$past(tptr_r[PTR_BITS-1:0]),
      $past(work_r)}) else $error("table address wrong");
   a_table_data: assert property ((state_r == ST_TABLE) |=>
      tdata_r == $past(rom_data[ROM_HI_LSB +: ROM_HI_W])
      && work_r == $past(rom_data[DW-1:0]) && $stable(carry_r))
      else $error("table data not loaded");
   a_t0_load: assert property ((exec_go && cmd_op_r == OP_T0_LOAD) |=>
      tmode_r == $past(work_r) && $stable(zero_r))
      else $error("timer mode load wrong");
   a_t0_read: assert property ((exec_go && cmd_op_r == OP_T0_READ) |=>
      work_r == $past(tmode_r) && state_r == ST_IDLE)
      else $error("timer mode read wrong");
   a_xor_zero: assert property (upd_zero |=> $stable(carry_r)
      && $stable(half_r)
      && zero_r == (($past(work_r) ^ $past(opnd)) == RST_BYTE))
      else $error("exclusive-or flags wrong");
   a_xor_imm: assert property ((exec_go && cmd_op_r == OP_XOR_IMM) |=>
      work_r == ($past(work_r) ^ $past(cmd_imm_r)))
      else $error("immediate exclusive-or wrong");
   a_cycle_count: assert property ((exec_go && cmd_op_r == OP_TABLE) |=>
      state_r == ST_TABLE ##1 state_r == ST_IDLE)
      else $error("table read not two cycles");

   c_sub_reg: cover property (exec_go && cmd_op_r == OP_SUB_REG);
   c_table: cover property (state_r == ST_TABLE);
   c_xor_file: cover property (wr_file && cmd_op_r == OP_XOR_REG);
   c_busy_drop: cover property (busy && wr_fire && paddr == OFF_CMD);

endmodule

// File: rtl/ssx_pkg.sv
// Shared constants for the subtract, swap, exclusive-OR and table datapath
package ssx_pkg;

   // ==========================================================
   // Datapath widths
   localparam int DATA_W = 8;
   localparam int NIB_W = 4;
   localparam int FILE_AW = 6;
   localparam int FILE_DEPTH = 64;
   localparam int PTR_BITS = 3;
   localparam int ROM_AW = 11;
   localparam int ROM_DW = 14;
   localparam int ROM_HI_LSB = 8;
   localparam int ROM_HI_W = 6;
   localparam int APB_AW = 8;
   localparam int APB_DW = 32;

   // ==========================================================
   // Operation codes carried in the command register
   localparam logic [3:0] OP_NOP = 4'h0;
   localparam logic [3:0] OP_SUB_REG = 4'h1;
   localparam logic [3:0] OP_SUB_IMM = 4'h2;
   localparam logic [3:0] OP_SWAP = 4'h3;
   localparam logic [3:0] OP_TABLE = 4'h4;
   localparam logic [3:0] OP_T0_LOAD = 4'h5;
   localparam logic [3:0] OP_T0_READ = 4'h6;
   localparam logic [3:0] OP_XOR_REG = 4'h7;
   localparam logic [3:0] OP_XOR_IMM = 4'h8;

   // ==========================================================
   // Command register fields
   localparam int CMD_OP_LSB = 0;
   localparam int CMD_OP_W = 4;
   localparam int CMD_TGT_BIT = 4;
   localparam int CMD_REG_LSB = 8;
   localparam int CMD_IMM_LSB = 16;

   // Status register fields
   localparam int ST_BUSY_BIT = 0;
   localparam int ST_ZERO_BIT = 1;
   localparam int ST_HALF_BIT = 2;
   localparam int ST_CARRY_BIT = 3;

   // ==========================================================
   // Register byte offsets
   localparam logic [7:0] OFF_CMD = 8'h00;
   localparam logic [7:0] OFF_STAT = 8'h04;
   localparam logic [7:0] OFF_WORK = 8'h08;
   localparam logic [7:0] OFF_TPTR = 8'h0C;
   localparam logic [7:0] OFF_TDATA = 8'h10;
   localparam logic [7:0] OFF_T0MODE = 8'h14;
   localparam logic [7:0] OFF_FADDR = 8'h18;
   localparam logic [7:0] OFF_FDATA = 8'h1C;

   // Reset values
   localparam logic [7:0] RST_BYTE = 8'h00;

   // Sequencer states
   typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_TABLE} ssx_state_t;

endpackage

// File: rtl/ssx_regfile.sv
// File of general data registers with one write and two read ports
`timescale 1ns/100ps
module ssx_regfile
   import ssx_pkg::*;
#(
   parameter int DW = DATA_W,
   parameter int AW = FILE_AW,
   parameter int DEPTH = FILE_DEPTH
)
(
   // Clock
   input wire logic clk,
   // Write port
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [DW-1:0] wdata,
   // Read ports, asynchronous
   input wire logic [AW-1:0] raddr_a,
   output logic [DW-1:0] rdata_a,
   input wire logic [AW-1:0] raddr_b,
   output logic [DW-1:0] rdata_b
);

   // ==========================================================
   // Storage holds data only, so it carries no reset
   logic [DW-1:0] mem [DEPTH];

   always_ff @(posedge clk)
   begin
      if (we)
         mem[waddr] <= wdata;
   end

   assign rdata_a = mem[raddr_a];
   assign rdata_b = mem[raddr_b];

endmodule

// File: verif/ssx_rom_model.sv
// Combinational program ROM model standing behind the table read port
`timescale 1ns/100ps
module ssx_rom_model
   import ssx_pkg::*;
(
   // Read request
   input wire logic [ROM_AW-1:0] rom_addr,
   input wire logic rom_rd,
   // Word out
   output logic [ROM_DW-1:0] rom_data
);
   // ==========================================================
   // Contents
   logic [ROM_DW-1:0] word;

   // Every address bit lands in the word, so a wrong address shows
   assign word = {rom_addr[10:8] ^ 3'h5, rom_addr[2:0], rom_addr[7:0] ^ 8'h9E};
   // Word is only promised while strobed; otherwise show its inverse
   assign rom_data = rom_rd ? word : ~word;
endmodule

// File: verif/subtract_swap_xor_table_exec_bench.sv
// Self-checking bench for the execution datapath over its APB registers
`timescale 1ns/100ps
`define CHK(nm, e, g) \
   begin \
      n_tests++; \
      if ((g) !== (e)) \
      begin \
         fail_count++; \
         $display("unexpected %s exp %h got %h", nm, e, g); \
      end \
   end
module subtract_swap_xor_table_exec_bench import ssx_pkg::*;;
   // ==========================================================
   // Signals and bench state
   logic pclk, presetn, psel, penable, pwrite, rom_rd, e;
   logic [7:0] paddr, t0m, r, w, d;
   logic [31:0] pwdata, prdata, q;
   logic pready, pslverr;
   logic [10:0] rom_addr, exp_ra;
   logic [13:0] rom_data, rw;
   logic [5:0] fa;
   int fail_count = 0;
   int n_tests = 0;
   logic [7:0] tr [6] = '{8'h05, 8'h06, 8'h00, 8'h10, 8'h80, 8'h3F};
   logic [7:0] tw [6] = '{8'h06, 8'h05, 8'h00, 8'h01, 8'h01, 8'h3F};

   ssx_exec_top i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rom_addr(rom_addr), .rom_rd(rom_rd), .rom_data(rom_data),
      .timer0_mode(t0m));
   ssx_rom_model i_rom (.rom_addr(rom_addr), .rom_rd(rom_rd),
      .rom_data(rom_data));

   // Free-running bus clock
   initial
   begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   // ==========================================================
   // Closing report
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // One APB transfer; an idle edge follows so psel never toggles twice
   task automatic xfer(input logic [7:0] a, input logic wd,
                       input logic [31:0] dt);
      int k;
      psel <= 1'b1;
      paddr <= a;
      pwrite <= wd;
      pwdata <= dt;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1)
      begin
         fail_count++;
         complete_run();
      end
      @(posedge pclk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] dt);
      xfer(a, 1'b1, dt);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] x,
                      input string nm);
      xfer(a, 1'b0, 32'h0);
      `CHK(nm, x, q)
   endtask

   // Issue a command, check the ROM strobe slot, then wait for idle
   task automatic exec(input logic [3:0] op, input logic tg,
                       input logic [5:0] f, input logic [7:0] im);
      int k;
      wr(OFF_CMD, {8'h00, im, 2'b00, f, 3'b000, tg, op});
      @(posedge pclk);
      `CHK("rom_rd", (op == OP_TABLE), rom_rd)
      if (op == OP_TABLE)
         `CHK("rom_addr", exp_ra, rom_addr)
      k = 0;
      q = 32'h1;
      while (q[0] !== 1'b0 && k < 10)
      begin
         xfer(OFF_STAT, 1'b0, 32'h0);
         k++;
      end
      // A late idle on the last poll must not count as a hang
      if (q[0] !== 1'b0)
      begin
         fail_count++;
         complete_run();
      end
   endtask

   function automatic logic [31:0] sub_st(input logic [7:0] m,
                                          input logic [7:0] s);
      logic [7:0] df;
      df = m - s;
      return {28'h0000000, m >= s, m[3:0] >= s[3:0], df == 8'h00, 1'b0};
   endfunction

   // ==========================================================
   // Main sequence
   initial
   begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      repeat (12) @(posedge pclk);
      `CHK("rst_t0", 8'h00, t0m)
      presetn <= 1'b1;
      @(posedge pclk);
      for (int i = 0; i < 7; i++)
         rdc(8'(i * 4), 32'h0, "reset");
      xfer(8'h20, 1'b0, 32'h0);
      `CHK("unmapped_err", 1'b1, e)
      `CHK("unmapped_data", 32'h0, q)
      // Subtractions over both targets and both ends of the file
      for (int i = 0; i < 6; i++)
      begin
         fa = (i < 3) ? 6'h00 : 6'h3F;
         d = tr[i] - tw[i];
         wr(OFF_FADDR, fa);
         wr(OFF_FDATA, tr[i]);
         wr(OFF_WORK, tw[i]);
         wr(OFF_STAT, 32'h0);
         exec(OP_SUB_REG, i[0], fa, 8'h00);
         rdc(OFF_STAT, sub_st(tr[i], tw[i]), "sub_flags");
         rdc(OFF_WORK, i[0] ? tw[i] : d, "sub_work");
         rdc(OFF_FDATA, i[0] ? d : tr[i], "sub_file");
         wr(OFF_WORK, tw[i]);
         wr(OFF_STAT, 32'hE);
         exec(OP_SUB_IMM, 1'b1, fa, tr[i]);
         rdc(OFF_WORK, d, "imm_work");
         rdc(OFF_STAT, sub_st(tr[i], tw[i]), "imm_flags");
      end
      // Swap and register exclusive-OR, each to both targets
      for (int j = 0; j < 4; j++)
      begin
         r = j[1] ? 8'h55 : 8'h5A;
         wr(OFF_FADDR, 6'h15);
         wr(OFF_FDATA, 8'hA5);
         wr(OFF_WORK, 8'hF0);
         wr(OFF_STAT, 32'hE);
         exec(j[1] ? OP_XOR_REG : OP_SWAP, j[0], 6'h15, 8'h00);
         rdc(OFF_WORK, j[0] ? 8'hF0 : r, "sx_work");
         rdc(OFF_FDATA, j[0] ? r : 8'hA5, "sx_file");
         rdc(OFF_STAT, j[1] ? 32'hC : 32'hE, "sx_flags");
      end
      // Immediate exclusive-OR: zero flag set, then cleared
      for (int j = 0; j < 2; j++)
      begin
         w = j[0] ? 8'hA5 : 8'hF0;
         wr(OFF_WORK, 8'hF0);
         wr(OFF_STAT, j[0] ? 32'hE : 32'hC);
         exec(OP_XOR_IMM, 1'b1, 6'h15, w);
         rdc(OFF_WORK, 8'hF0 ^ w, "xi_work");
         rdc(OFF_STAT, j[0] ? 32'hC : 32'hE, "xi_flags");
      end
      // Timer mode moves leave the flags alone
      wr(OFF_WORK, 8'hAA);
      wr(OFF_STAT, 32'h6);
      exec(OP_T0_LOAD, 1'b0, 6'h00, 8'h00);
      `CHK("t0_port", 8'hAA, t0m)
      rdc(OFF_T0MODE, 8'hAA, "t0_reg");
      rdc(OFF_STAT, 32'h6, "t0_flags");
      wr(OFF_T0MODE, 8'h55);
      exec(OP_T0_READ, 1'b1, 6'h00, 8'h00);
      rdc(OFF_WORK, 8'h55, "t0r_work");
      rdc(OFF_STAT, 32'h6, "t0r_flags");
      // Table reads: upper pointer bits must be ignored
      for (int j = 0; j < 2; j++)
      begin
         exp_ra = j[0] ? 11'h7FF : 11'h234;
         rw = {exp_ra[10:8] ^ 3'h5, exp_ra[2:0], exp_ra[7:0] ^ 8'h9E};
         wr(OFF_TPTR, j[0] ? 8'h07 : 8'hFA);
         wr(OFF_WORK, exp_ra[7:0]);
         wr(OFF_TDATA, 32'h0);
         wr(OFF_STAT, 32'hA);
         exec(OP_TABLE, 1'b0, 6'h00, 8'h00);
         rdc(OFF_WORK, rw[7:0], "tbl_work");
         rdc(OFF_TDATA, rw[13:8], "tbl_data");
         rdc(OFF_STAT, 32'hA, "tbl_flags");
      end
      complete_run();
   end
endmodule
